// >>> hdl/dios_in_chan.sv
`timescale 1ns/1ps
`include "dios_cfg.svh"
// One input channel: synchroniser, debounce, stretch
module dios_in_chan #(
    parameter int CW = 25
) (
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          pin_in,
    input  wire logic [CW-1:0] flt_cycles,
    input  wire logic [CW-1:0] ext_cycles,
    output logic               level_out
);
    logic          sync1_r;
    logic          sync2_r;
    logic          stable_r;
    logic [CW-1:0] flt_cnt_r;
    logic [CW-1:0] ext_cnt_r;

    // Two-stage synchroniser
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // Debounce counter, accepts level after full filter time
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stable_r  <= 1'b0;
            flt_cnt_r <= '0;
        end else if (sync2_r == stable_r) begin
            flt_cnt_r <= '0; // RL1
        end else if (flt_cnt_r + 1'b1 >= flt_cycles) begin
            stable_r  <= sync2_r; // RL8
            flt_cnt_r <= '0;
        end else begin
            flt_cnt_r <= flt_cnt_r + 1'b1; // RL8
        end
    end

    // Stretch: each accepted change holds the output for the stretch time
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level_out <= 1'b0;
            ext_cnt_r <= '0;
        end else if (ext_cnt_r != '0) begin
            ext_cnt_r <= ext_cnt_r - 1'b1; // RL2
        end else if (stable_r != level_out) begin
            level_out <= stable_r;
            ext_cnt_r <= ext_cycles - 1'b1; // RL2
        end
    end
endmodule

// >>> hdl/dios_supervisor.sv
`timescale 1ns/1ps
`include "dios_cfg.svh"
//
// Contract
// RL1: Ignore input changes shorter than filter time.
// RL2: Hold detected input for selected stretch time.
// RL3: Inrush enabled masks overcurrent for 100 ms.
// RL4: Auto recovery clears short error when gone.
// RL5: Manual recovery latches short error until power-up.
// RL6: Comm loss applies per-channel off, hold, force-on.
// RL7: Configurer disables short detect for lamp loads.
// RL8: Filter counter accepts level after stable time.
module dios_supervisor #(
    parameter int N_IN       = 8,
    parameter int N_OUT      = 8,
    parameter int CW         = 25,
    parameter int INRUSH_CYC = `DIOS_INRUSH_US * (`DIOS_CLK_KHZ / 1000)
) (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire dios_pkg::dios_cfg_t        unit_cfg,
    input  wire logic [N_IN-1:0]            field_in,
    output logic [N_IN-1:0]                 input_data,
    input  wire logic [N_OUT-1:0]           output_cmd,
    input  wire logic [2*N_OUT-1:0]         comm_loss_output_action,
    input  wire logic                       comm_fault,
    input  wire logic                       handheld_priority,
    output logic [N_OUT-1:0]                field_out,
    output logic [N_OUT-1:0]                drive_on_forced,
    input  wire logic                       power_on,
    input  wire logic                       over_current_in,
    input  wire logic                       output_short_in,
    input  wire logic                       supply_short_in,
    input  wire logic [N_OUT-1:0]           open_wire_in,
    output logic [N_OUT-1:0]                open_wire_err,
    output dios_pkg::dios_err_t             unit_err
);
    localparam int CPU = `DIOS_CLK_KHZ / 1000; // Cycles per microsecond

    logic [CW-1:0]      flt_cycles_r;
    logic [CW-1:0]      ext_cycles_r;
    logic [N_IN-1:0]    in_level;
    logic [2:0]         pin_s1_r;
    logic [2:0]         pin_s2_r;
    logic [N_OUT-1:0]   ow_s1_r;
    logic [N_OUT-1:0]   ow_s2_r;
    logic               pwr_d_r;
    logic [CW-1:0]      inrush_cnt_r;
    logic [N_OUT-1:0]   out_nxt;
    logic [N_OUT-1:0]   force_nxt;
    logic               loss_active;

    // Filter time from selector
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flt_cycles_r <= CW'(`DIOS_FLT_T1_US * CPU);
        end else begin
            case (unit_cfg.filter_sel)
                2'h0:    flt_cycles_r <= CW'(`DIOS_FLT_T0_US * CPU); // RL1
                2'h1:    flt_cycles_r <= CW'(`DIOS_FLT_T1_US * CPU);
                2'h2:    flt_cycles_r <= CW'(`DIOS_FLT_T2_US * CPU);
                default: flt_cycles_r <= CW'(`DIOS_FLT_T3_US * CPU);
            endcase
        end
    end

    // Stretch time from selector
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_cycles_r <= CW'(`DIOS_EXT_T1_US * CPU);
        end else begin
            case (unit_cfg.input_stretch_time_sel)
                2'h0:    ext_cycles_r <= CW'(`DIOS_EXT_T0_US * CPU); // RL2
                2'h1:    ext_cycles_r <= CW'(`DIOS_EXT_T1_US * CPU);
                2'h2:    ext_cycles_r <= CW'(`DIOS_EXT_T2_US * CPU);
                default: ext_cycles_r <= CW'(`DIOS_EXT_T3_US * CPU);
            endcase
        end
    end

    // Input channels
    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_in
            dios_in_chan #(
                .CW (CW)
            ) u_chan (
                .clk        (clk),
                .sys_rst    (sys_rst),
                .pin_in     (field_in[gi]),
                .flt_cycles (flt_cycles_r),
                .ext_cycles (ext_cycles_r),
                .level_out  (in_level[gi])
            );
        end
    endgenerate

    // Registered input image
    always_ff @(posedge clk) begin
        if (sys_rst) input_data <= '0;
        else         input_data <= in_level;
    end

    // Synchronise fault sense pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            ow_s1_r  <= '0;
            ow_s2_r  <= '0;
        end else begin
            pin_s1_r <= {supply_short_in, output_short_in, over_current_in};
            pin_s2_r <= pin_s1_r;
            ow_s1_r  <= open_wire_in;
            ow_s2_r  <= ow_s1_r;
        end
    end

    // Inrush window opens on power-on rising edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwr_d_r      <= 1'b0;
            inrush_cnt_r <= '0;
        end else begin
            pwr_d_r <= power_on;
            if (power_on && !pwr_d_r) begin
                inrush_cnt_r <= CW'(INRUSH_CYC); // RL3
            end else if (inrush_cnt_r != '0) begin
                inrush_cnt_r <= inrush_cnt_r - 1'b1;
            end
        end
    end

    // Unit error flags
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            unit_err <= '0;
        end else begin
            unit_err.over_current_err <= pin_s2_r[0] &&
                !(unit_cfg.inrush_filter_en && inrush_cnt_r != '0); // RL3
            unit_err.supply_short_err <= pin_s2_r[2] && unit_cfg.sensor_supply_short_detect_en;
            if (!unit_cfg.output_short_detect_en) begin
                unit_err.output_short_err <= 1'b0; // RL7
            end else if (pin_s2_r[1]) begin
                unit_err.output_short_err <= 1'b1;
            end else if (!unit_cfg.output_short_recovery_mode) begin
                unit_err.output_short_err <= 1'b0; // RL4
            end
            // Manual mode: held until sys_rst at power-up or output_short_detect_en goes low  // RL5
        end
    end

    // Per-channel open wire errors
    always_ff @(posedge clk) begin
        if (sys_rst) open_wire_err <= '0;
        else         open_wire_err <= ow_s2_r & {N_OUT{unit_cfg.open_wire_detect_en}};
    end

    assign loss_active = comm_fault && handheld_priority; // RL6

    // Safe-state selection per channel
    always_comb begin
        for (int i = 0; i < N_OUT; i++) begin
            out_nxt[i]   = output_cmd[i];
            force_nxt[i] = 1'b0;
            if (loss_active) begin
                case (dios_pkg::dios_act_t'(comm_loss_output_action[2*i +: 2]))
                    dios_pkg::DIOS_ACT_CLEAR: out_nxt[i] = 1'b0; // RL6
                    dios_pkg::DIOS_ACT_HOLD:  out_nxt[i] = field_out[i];
                    dios_pkg::DIOS_ACT_FORCE: begin
                        out_nxt[i]   = 1'b1;
                        force_nxt[i] = 1'b1;
                    end
                    default:                  out_nxt[i] = 1'b0;
                endcase
            end
        end
    end

    // Output drive registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            field_out       <= '0;
            drive_on_forced <= '0;
        end else begin
            field_out       <= out_nxt;
            drive_on_forced <= force_nxt;
        end
    end
endmodule

// >>> shared/dios_cfg.svh
`ifndef DIOS_CFG_SVH
`define DIOS_CFG_SVH
// Clock rate in kHz, so that cycles per ms are exact
`define DIOS_CLK_KHZ        100000
// Filter times in microseconds
`define DIOS_FLT_T0_US      100
`define DIOS_FLT_T1_US      1000
`define DIOS_FLT_T2_US      10000
`define DIOS_FLT_T3_US      20000
// Stretch times in microseconds
`define DIOS_EXT_T0_US      1000
`define DIOS_EXT_T1_US      15000
`define DIOS_EXT_T2_US      100000
`define DIOS_EXT_T3_US      200000
// Inrush mask window in microseconds
`define DIOS_INRUSH_US      100000
// Reset selections
`define DIOS_FLT_SEL_RST    2'h1
`define DIOS_EXT_SEL_RST    2'h1
`endif

// >>> shared/dios_pkg.sv
package dios_pkg;
    // Time selector for filter and stretch
    typedef logic [1:0] dios_tsel_t;

    // Action on communication loss
    typedef enum logic [1:0] {
        DIOS_ACT_CLEAR = 2'h0,
        DIOS_ACT_HOLD  = 2'h1,
        DIOS_ACT_FORCE = 2'h2
    } dios_act_t;

    // Per-unit configuration
    typedef struct packed {
        dios_tsel_t filter_sel;
        dios_tsel_t input_stretch_time_sel;
        logic       inrush_filter_en;
        logic       output_short_detect_en;
        logic       output_short_recovery_mode; // 1 = manual
        logic       sensor_supply_short_detect_en;
        logic       open_wire_detect_en;
    } dios_cfg_t;

    // Per-unit error status
    typedef struct packed {
        logic supply_short_err;
        logic over_current_err;
        logic output_short_err;
    } dios_err_t;
endpackage

// >>> test/dios_field_model.sv
`timescale 1ns/1ps
// Field side: a sensor, a feedback contact and a load that may short
module dios_field_model (
    input  wire logic       sens,
    input  wire logic       load_short,
    input  wire logic       load_oc,
    input  wire logic [1:0] field_out,
    output logic [1:0]      field_in,
    output logic            output_short_in,
    output logic            over_current_in
);
    // Channel 1 input reads back the drive of output 1
    assign field_in        = {field_out[1], sens};
    assign output_short_in = load_short;
    assign over_current_in = load_oc;
endmodule

// >>> test/dios_sup_monitor.sv
`timescale 1ns/1ps
// Port checks for the supervisor, channel 0 on the wide buses, both channels in the command-follow check
module dios_sup_monitor (
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire dios_pkg::dios_cfg_t unit_cfg,
    input wire logic [1:0]          field_in,
    input wire logic [1:0]          input_data,
    input wire logic [1:0]          output_cmd,
    input wire logic [3:0]          comm_loss_output_action,
    input wire logic                comm_fault,
    input wire logic                handheld_priority,
    input wire logic [1:0]          field_out,
    input wire logic [1:0]          drive_on_forced,
    input wire logic                over_current_in,
    input wire logic                output_short_in,
    input wire dios_pkg::dios_err_t unit_err
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Safe state selected for channel 0
    sequence s_act(logic [1:0] c);
        comm_fault && handheld_priority && comm_loss_output_action[1:0] == c;
    endsequence
    // Short gone for long enough in auto mode
    sequence s_no_short;
        (!output_short_in && !unit_cfg.output_short_recovery_mode)[*5];
    endsequence
    a_comm_off: assert property (s_act(2'h0) |=> !field_out[0])
        else $error("channel not off");
    a_comm_force: assert property (s_act(2'h2) |=> field_out[0] && drive_on_forced[0])
        else $error("channel not forced");
    a_comm_hold: assert property (s_act(2'h1) ##1 s_act(2'h1) |=> $stable(field_out[0]))
        else $error("channel not held");
    a_cmd_follow: assert property (!(comm_fault && handheld_priority)
        |=> field_out == $past(output_cmd)) else $error("command not followed");
    a_short_auto: assert property (s_no_short |-> !unit_err.output_short_err)
        else $error("short error stuck");
    a_short_latch: assert property (unit_err.output_short_err && unit_cfg.output_short_detect_en
        && unit_cfg.output_short_recovery_mode |=> unit_err.output_short_err)
        else $error("short error lost");
    a_oc_unmasked: assert property ((over_current_in && !unit_cfg.inrush_filter_en)[*5]
        |-> unit_err.over_current_err) else $error("overcurrent missed");
    a_filter_rise: assert property ($rose(input_data[0]) |-> $past(field_in[0], 8))
        else $error("input rose without stable level");
    a_stretch_hold: assert property ($rose(input_data[0]) |=> input_data[0] [*8])
        else $error("input not stretched");
endmodule
bind dios_supervisor dios_sup_monitor u_mon (.clk, .sys_rst, .unit_cfg, .field_in, .input_data,
    .output_cmd, .comm_loss_output_action, .comm_fault, .handheld_priority, .field_out,
    .drive_on_forced, .over_current_in, .output_short_in, .unit_err);

// >>> test/dios_supervisor_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("BAD %0t value mismatch", $time); end end
module dios_supervisor_tb;
    logic                clk;
    logic                sys_rst = 1'h1, comm_fault = 1'h0, handheld_priority = 1'h0;
    logic                power_on = 1'h0, sens = 1'h0, load_short = 1'h0, load_oc = 1'h0;
    logic                supply_sh = 1'h0;
    logic [1:0]          field_in, input_data, field_out, drive_on_forced, open_wire_err;
    logic [1:0]          output_cmd = 2'h0, open_wire_in = 2'h0;
    logic [3:0]          act = 4'h0, exp_r = 4'h0;
    logic                output_short_in, over_current_in;
    dios_pkg::dios_cfg_t cfg = '0;
    dios_pkg::dios_err_t unit_err;
    int                  num_errors = 0, total_checks = 0;
    dios_supervisor #(.N_IN(2), .N_OUT(2), .INRUSH_CYC(100)) uut (.clk, .sys_rst,
        .unit_cfg(cfg), .field_in, .input_data, .output_cmd, .comm_loss_output_action(act),
        .comm_fault, .handheld_priority, .field_out, .drive_on_forced, .power_on,
        .over_current_in, .output_short_in, .supply_short_in(supply_sh), .open_wire_in,
        .open_wire_err, .unit_err);
    dios_field_model u_field (.sens, .load_short, .load_oc, .field_out, .field_in,
        .output_short_in, .over_current_in);
    // Expected {forced, drive} from present inputs and last drive
    function automatic logic [3:0] exp_f(logic [1:0] prev);
        logic [3:0] r;
        r = {2'h0, output_cmd};
        for (int i = 0; i < 2; i++) begin
            if (comm_fault && handheld_priority) begin
                r[i]   = (act[2*i+:2] == 2'h1) ? prev[i] : (act[2*i+:2] == 2'h2);
                r[i+2] = (act[2*i+:2] == 2'h2);
            end
        end
        return r;
    endfunction
    task automatic hold(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic finish_test();
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // Watchdog well past the expected run
    initial begin
        #500000;
        num_errors++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h4136));
        repeat (10) @(posedge clk);
        sys_rst <= 1'h0;
        hold(2);
        `CHK(unit_err, 3'h0)
        // Random commands, actions and comm faults
        repeat (60) begin
            @(posedge clk) output_cmd <= 2'($urandom);
            act <= 4'($urandom);
            comm_fault <= 1'($urandom);
            handheld_priority <= 1'($urandom);
            hold(2);
            exp_r = exp_f(exp_r[1:0]);
            `CHK({drive_on_forced, field_out}, exp_r)
        end
        // Short error, auto then manual, then detection off for a lamp load
        @(posedge clk) comm_fault <= 1'h0;
        cfg.output_short_detect_en <= 1'h1;
        load_short <= 1'h1;
        // Channel 1 drive held on, read back through the input filter
        output_cmd <= 2'h2;
        supply_sh <= 1'h1;
        open_wire_in <= 2'h3;
        hold(6);
        `CHK(unit_err.output_short_err, 1'h1)
        `CHK(unit_err.supply_short_err, 1'h0)
        `CHK(open_wire_err, 2'h0)
        @(posedge clk) load_short <= 1'h0;
        hold(6);
        `CHK(unit_err.output_short_err, 1'h0)
        @(posedge clk) cfg.output_short_recovery_mode <= 1'h1;
        load_short <= 1'h1;
        hold(6);
        @(posedge clk) load_short <= 1'h0;
        hold(20);
        `CHK(unit_err.output_short_err, 1'h1)
        @(posedge clk) cfg.output_short_detect_en <= 1'h0;
        hold(6);
        `CHK(unit_err.output_short_err, 1'h0)
        // Supply short and open wire raise errors once enabled
        @(posedge clk) cfg.sensor_supply_short_detect_en <= 1'h1;
        cfg.open_wire_detect_en <= 1'h1;
        open_wire_in <= 2'h2;
        hold(6);
        `CHK(unit_err.supply_short_err, 1'h1)
        `CHK(open_wire_err, 2'h2)
        // Overcurrent inside and after the inrush window, then unmasked
        @(posedge clk) cfg.inrush_filter_en <= 1'h1;
        power_on <= 1'h1;
        load_oc <= 1'h1;
        hold(50);
        `CHK(unit_err.over_current_err, 1'h0)
        hold(60);
        `CHK(unit_err.over_current_err, 1'h1)
        @(posedge clk) cfg.inrush_filter_en <= 1'h0;
        power_on <= 1'h0;
        load_oc <= 1'h0;
        hold(6);
        @(posedge clk) power_on <= 1'h1;
        load_oc <= 1'h1;
        hold(6);
        `CHK(unit_err.over_current_err, 1'h1)
        // Filter at 0.1 ms: random short pulse, then a long level
        @(posedge clk) sens <= 1'h1;
        hold(9000 + $urandom % 900);
        @(posedge clk) sens <= 1'h0;
        hold(30);
        `CHK(input_data[0], 1'h0)
        @(posedge clk) sens <= 1'h1;
        hold(9990);
        `CHK(input_data[0], 1'h0)
        hold(30);
        `CHK(input_data[0], 1'h1)
        `CHK(input_data[1], 1'h1)
        @(posedge clk) sens <= 1'h0;
        hold(12000);
        `CHK(input_data[0], 1'h1)
        finish_test();
    end
endmodule
